// >>> dv/data_buffer_and_stack_bench.sv
// self-checking bench for the transfer buffer and its save stack
`timescale 1ns/1ps
module data_buffer_and_stack_bench;
  import dbfs_pkg::*;
  logic clk = 0, srst = 1, wdtReset = 0, clkStop = 0, instrValid = 0, memWrite = 0, ctrlWrite = 0, tick = 0;
  dbfs_instr_type instrKind = INSTR_NONE;
  logic [ADDR_W-1:0] periphAddr = 0, memAddr = 0, ctrlAddr = CA_LEVEL;
  logic [BANK_W-1:0] memBank = 0;
  logic [NIB_W-1:0] memWData = 0, ctrlWData = 0, memRData, ctrlRData;
  logic memHit, addrStackUse, timerUpdate, freqUpdate, shiftLoad;
  logic [BUF_W-1:0] progAddr, progData, transferBuffer, freqCount;
  logic [BYTE_W-1:0] compareValue, shiftValue, moduloValue, timerCount, shiftIn;
  logic [BUF_W:0] divideValue;
  int err_count = 0, n_tests = 0, seed = 84, cycles = 0;
  // reference model state
  int mBuf = 0, ptr = 0, wid = 0, low = 0, tv = 0, fv = 0;
  int stk[4] = '{0, 0, 0, 0};
  int regs[int];
  logic [ADDR_W-1:0] addrs[9] = '{PA_COMPARE, PA_SHIFT, PA_MODULO, PA_TABLE, PA_DIVIDE, PA_COUNT, PA_FREQ, 7'h05, 7'h7f};

  dbfs_buffer dut (.clk, .srst, .wdtReset, .clkStop, .instrValid, .instrKind, .periphAddr, .memWrite, .memBank,
    .memAddr, .memWData, .memRData, .memHit, .ctrlWrite, .ctrlAddr, .ctrlWData, .ctrlRData, .progAddr, .progData,
    .addrStackUse, .transferBuffer, .compareValue, .shiftValue, .shiftLoad, .shiftIn, .moduloValue, .timerCount,
    .timerUpdate, .divideValue, .freqCount, .freqUpdate);
  dbfs_core_model core (.clk, .tick, .progAddr, .progData, .timerCount, .timerUpdate, .freqCount, .freqUpdate,
    .shiftLoad, .shiftIn);

  // 200 MHz clock
  always #2.5 clk = ~clk;
  // hang guard: the run needs under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // the single compare; values are four-state, so unknowns never match
  task automatic chkVal(input logic [BUF_W:0] got, input logic [BUF_W:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // buffer, level and every register output against the model
  task automatic checkAll();
    chkVal(transferBuffer, 17'(mBuf & 'hffff), "buffer");
    chkVal(17'(ctrlRData), 17'(ptr), "level");
    chkVal(17'(compareValue), 17'(regs[2]), "compare");
    chkVal(17'(shiftValue), 17'(regs[4]), "shift");
    chkVal(17'(moduloValue), 17'(regs['h1a]), "modulo");
    chkVal(17'(progAddr), 17'(regs['h40]), "pointer");
    chkVal(divideValue, 17'(regs['h42] * 2 + low), "divider");
  endtask

  // nibble writes through the data memory path, msb nibble first
  task automatic setBuf(input int v);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      memWrite <= 1;
      memBank <= DATA_BANK_ZERO;
      memAddr <= NIB3_ADDR + 7'(i);
      memWData <= 4'(v >> (12 - 4 * i));
      @(posedge clk);
      memWrite <= 0;
      mBuf = (mBuf & ~(15 << (12 - 4 * i))) | (v & (15 << (12 - 4 * i)));
      #1 chkVal(17'(memRData), 17'((mBuf >> (12 - 4 * i)) & 15), "nibble");
    end
    checkAll();
  endtask

  // one instruction, then the model follows it
  task automatic doIns(input dbfs_instr_type k, input logic [ADDR_W-1:0] a);
    int pd;
    @(posedge clk);
    instrValid <= 1;
    instrKind <= k;
    periphAddr <= a;
    pd = (regs['h40] ^ 'ha55a) & (wid ? 'hff : 'hffff);
    @(posedge clk);
    instrValid <= 0;
    if (k == INSTR_TABLE) mBuf = wid ? (mBuf & 'hff00) | pd : pd;
    else if (k == INSTR_STORE) begin
      if (a == PA_STACK) begin
        stk[ptr] = mBuf;
        ptr = (ptr + 1) % 4;
      end else if (a inside {PA_COMPARE, PA_SHIFT, PA_MODULO}) regs[a] = mBuf & 'hff;
      else if (regs.exists(a)) regs[a] = mBuf;
    end else if (k == INSTR_LOAD) begin
      if (a == PA_STACK) begin
        mBuf = stk[ptr];
        ptr = (ptr + 3) % 4;
      end else if (regs.exists(a)) mBuf = regs[a];
      else if (a == PA_COUNT) mBuf = tv ? 'h3c : 0;
      else if (a == PA_FREQ) mBuf = fv ? 'h5e17 : 0;
      else mBuf = UNDEF_VAL;
    end
    #1 chkVal(17'(addrStackUse), 17'(k == INSTR_TABLE), "stack use");
    checkAll();
  endtask

  task automatic ctrlWr(input logic [ADDR_W-1:0] a, input logic [NIB_W-1:0] d);
    @(posedge clk);
    ctrlWrite <= 1;
    ctrlAddr <= a;
    ctrlWData <= d;
    @(posedge clk);
    ctrlWrite <= 0;
    if (a == CA_WIDTH) wid = d[0];
    if (a == CA_DIVLOW) low = d[0];
    #1 chkVal(17'(ctrlRData), 17'(a == CA_WIDTH ? wid : a == CA_DIVLOW ? low : ptr), "control read");
    @(posedge clk);
    ctrlAddr <= CA_LEVEL;
    #1 checkAll();
  endtask

  // 0 watchdog reset, 1 clock stop, 2 partner update tick
  task automatic evt(input int w);
    @(posedge clk);
    wdtReset <= (w == 0);
    clkStop <= (w == 1);
    tick <= (w == 2);
    @(posedge clk);
    wdtReset <= 0;
    clkStop <= 0;
    tick <= 0;
    if (w == 0) begin
      ptr = 0;
      wid = 0;
      low = 0;
      regs[2] = 0;
      regs['h40] = 0;
    end
    if (w < 2) begin
      regs['h1a] = 'hff;
      tv = 0;
      fv = 0;
    end else begin
      tv = 1;
      fv = 1;
      regs[4] = 'h96;
    end
    #1 checkAll();
  endtask

  initial begin
    regs = '{2: 0, 4: 0, 'h1a: 'hff, 'h40: 0, 'h42: 0};
    repeat (6) @(posedge clk);
    srst <= 0;
    #1 checkAll();
    // count sources read zero until they update, and again after a stop
    for (int i = 0; i < 3; i++) begin
      doIns(INSTR_LOAD, PA_COUNT);
      doIns(INSTR_LOAD, PA_FREQ);
      evt(i == 0 ? 2 : 1);
    end
    // store then load every address but the stack, unmapped and load-only among them
    foreach (addrs[i]) begin
      setBuf($random(seed));
      doIns(INSTR_STORE, addrs[i]);
      setBuf($random(seed));
      doIns(INSTR_LOAD, addrs[i]);
    end
    ctrlWr(CA_LEVEL, 4'hf);
    ctrlWr(CA_DIVLOW, 4'h1);
    // a write into another bank must not reach the buffer
    @(posedge clk);
    memWrite <= 1;
    memBank <= 4'h3;
    memAddr <= NIB3_ADDR;
    memWData <= 4'h9;
    @(posedge clk);
    memWrite <= 0;
    #1 chkVal(17'(memHit), 17'h0, "bank hit");
    checkAll();
    // five pushes wrap over the oldest entry, the first with the bank still elsewhere
    for (int i = 0; i < 5; i++) begin
      if (i > 0) setBuf($random(seed));
      doIns(INSTR_STORE, PA_STACK);
    end
    repeat (3) doIns(INSTR_LOAD, PA_STACK);
    // table reads in both widths
    setBuf($random(seed));
    doIns(INSTR_STORE, PA_TABLE);
    doIns(INSTR_TABLE, 0);
    ctrlWr(CA_WIDTH, 4'h1);
    setBuf($random(seed) & 'hff);
    doIns(INSTR_TABLE, 0);
    evt(0);
    // random traffic, compared at every step
    for (int i = 0; i < 60; i++) begin
      setBuf($random(seed));
      doIns(dbfs_instr_type'($random(seed) & 3), ($random(seed) & 1) ? PA_STACK : addrs[($random(seed) & 'hff) % 9]);
    end
    test_done();
  end
endmodule

// >>> dv/dbfs_core_model.sv
// far-side model: program memory, timer, frequency counter, serial unit
`timescale 1ns/1ps
module dbfs_core_model
  import dbfs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              tick,
  input  wire logic [BUF_W-1:0]  progAddr,
  output logic      [BUF_W-1:0]  progData,
  output logic      [BYTE_W-1:0] timerCount,
  output logic                   timerUpdate,
  output logic      [BUF_W-1:0]  freqCount,
  output logic                   freqUpdate,
  output logic                   shiftLoad,
  output logic      [BYTE_W-1:0] shiftIn
);
  // each program word differs from its neighbours, so a wrong address shows
  assign progData = progAddr ^ 16'ha55a;
  // fixed counts; updates follow the tick, so the zero-after-reset window is ours to pick
  assign timerCount = 8'h3c;
  assign freqCount = 16'h5e17;
  // the core never saves buffer or stack by itself; software does it
  assign timerUpdate = tick;
  assign freqUpdate = tick;
  assign shiftLoad = tick;
  assign shiftIn = 8'h96;
endmodule

// >>> hw/dbfs_buffer.sv
// transfer buffer between the core and the peripheral registers
`timescale 1ns/1ps
// What this block does
// RULE_01 - buffer is nibbles 0ch..0fh of bank zero
// RULE_02 - data memory instructions reach the buffer nibbles
// RULE_03 - table read copies program word at pointer
// RULE_04 - control 07h picks width; byte fills low
// RULE_05 - table read holds one address stack level
// RULE_06 - peripheral load copies selected register to buffer
// RULE_07 - peripheral store writes buffer into selected register
// RULE_08 - 02h, 04h, 1ah read/write eight bits
// RULE_09 - 1bh timer count load only, zero after resets
// RULE_10 - 40h, 42h sixteen bit; pointer clears on reset
// RULE_11 - 43h frequency result load only, zero after resets
// RULE_12 - divider seventeen bits, low bit at control 10h
// RULE_13 - timer modulo becomes ff on resets, stop
// RULE_14 - bad loads undefined, bad stores change nothing
// RULE_15 - four word stack at peripheral address 41h
// RULE_16 - stack store writes at pointer then increments
// RULE_17 - stack load reads at pointer then decrements
// RULE_18 - pointer starts zero, counts modulo four
// RULE_19 - fifth store overwrites the oldest entry
// RULE_20 - pointer read-only at control 04h, bits 1:0
// RULE_21 - interrupts never save buffer or stack automatically
// RULE_22 - peripheral transfers always use the bank zero buffer
// RULE_23 - each transfer completes within one instruction
module dbfs_buffer
  import dbfs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 wdtReset,
  input  wire logic                 clkStop,
  input  wire logic                 instrValid,
  input  wire dbfs_instr_type       instrKind,
  input  wire logic [ADDR_W-1:0]    periphAddr,
  input  wire logic                 memWrite,
  input  wire logic [BANK_W-1:0]    memBank,
  input  wire logic [ADDR_W-1:0]    memAddr,
  input  wire logic [NIB_W-1:0]     memWData,
  output logic      [NIB_W-1:0]     memRData,
  output logic                      memHit,
  input  wire logic                 ctrlWrite,
  input  wire logic [ADDR_W-1:0]    ctrlAddr,
  input  wire logic [NIB_W-1:0]     ctrlWData,
  output logic      [NIB_W-1:0]     ctrlRData,
  output logic      [BUF_W-1:0]     progAddr,
  input  wire logic [BUF_W-1:0]     progData,
  output logic                      addrStackUse,
  output logic      [BUF_W-1:0]     transferBuffer,
  output logic      [BYTE_W-1:0]    compareValue,
  output logic      [BYTE_W-1:0]    shiftValue,
  input  wire logic                 shiftLoad,
  input  wire logic [BYTE_W-1:0]    shiftIn,
  output logic      [BYTE_W-1:0]    moduloValue,
  input  wire logic [BYTE_W-1:0]    timerCount,
  input  wire logic                 timerUpdate,
  output logic      [BUF_W:0]       divideValue,
  input  wire logic [BUF_W-1:0]     freqCount,
  input  wire logic                 freqUpdate
);
  // all state of the block but the save stack
  typedef struct packed {
    logic [BUF_W-1:0]  buffer;    // transfer buffer
    logic [BUF_W-1:0]  tablePtr;  // table address register
    logic [BYTE_W-1:0] compare;   // converter compare value
    logic [BYTE_W-1:0] shift;     // serial shift register
    logic [BYTE_W-1:0] modulo;    // timer modulo value
    logic [BUF_W-1:0]  divide;    // divider upper sixteen bits
    logic              divLow;    // divider lowest bit
    logic              narrow;    // table read moves one byte
    logic              countZero; // timer count reads zero
    logic              freqZero;  // frequency result reads zero
    logic              stackUse;  // address stack level held
  } dbfs_state_type;

  localparam dbfs_state_type RESET_STATE = '{
    buffer:    '0,
    tablePtr:  '0,
    compare:   '0,
    shift:     '0,
    modulo:    MODULO_RST,
    divide:    '0,
    divLow:    1'b0,
    narrow:    1'b0,
    countZero: 1'b1,
    freqZero:  1'b1,
    stackUse:  1'b0
  };

  dbfs_state_type st;      // registered state
  dbfs_state_type next_st; // next state

  logic               stackPush;  // store to stack address
  logic               stackPop;   // load from stack address
  logic [BUF_W-1:0]   stackTop;   // entry at the pointer
  logic [LEVEL_W-1:0] stackLevel; // pointer value
  logic               bankHit;    // data access lands on a buffer nibble of bank zero
  logic [1:0]         nibSel;     // nibble index, 3 is msb

  // save stack; only explicit loads and stores and the pin and watchdog resets move it, never an interrupt
  dbfs_stack u_stack (
    .clk        (clk),
    .srst       (srst),
    .levelClear (wdtReset),
    .push       (stackPush),
    .pop        (stackPop),
    .pushData   (st.buffer),
    .popData    (stackTop),
    .level      (stackLevel)
  ); // [RULE_15] [RULE_21]

  // data memory decode of the buffer nibbles
  always_comb begin
    bankHit = 1'b0;
    nibSel  = 2'h0;
    // only bank zero holds the buffer; other banks never alias it
    if (memBank == DATA_BANK_ZERO) begin
      case (memAddr)
        NIB3_ADDR: begin
          bankHit = 1'b1;
          nibSel  = 2'h3;
        end
        NIB2_ADDR: begin
          bankHit = 1'b1;
          nibSel  = 2'h2;
        end
        NIB1_ADDR: begin
          bankHit = 1'b1;
          nibSel  = 2'h1;
        end
        NIB0_ADDR: begin
          bankHit = 1'b1;
          nibSel  = 2'h0;
        end
        default: begin
          bankHit = 1'b0;
        end
      endcase
    end
  end

  // next state: data memory, instruction transfers, control bits, resets
  always_comb begin
    next_st          = st;
    next_st.stackUse = 1'b0;
    stackPush        = 1'b0;
    stackPop         = 1'b0;
    // peripheral side updates; a shift store below overrides the shift load, a stop or watchdog reset the count flags
    if (shiftLoad) begin
      next_st.shift = shiftIn;
    end
    if (timerUpdate) begin
      next_st.countZero = 1'b0;
    end
    if (freqUpdate) begin
      next_st.freqZero = 1'b0;
    end
    // ordinary data memory write; a load or table read in the same cycle wins where both write
    if (memWrite && bankHit) begin
      next_st.buffer[nibSel*NIB_W +: NIB_W] = memWData; // [RULE_01] [RULE_02]
    end
    if (instrValid) begin
      // bank selection is ignored here: the buffer is always bank zero
      case (instrKind)
        INSTR_TABLE: begin
          if (st.narrow) begin
            next_st.buffer[BYTE_W-1:0] = progData[BYTE_W-1:0]; // [RULE_04]
          end else begin
            next_st.buffer = progData; // [RULE_03]
          end
          next_st.stackUse = 1'b1; // [RULE_05]
        end
        INSTR_LOAD: begin
          case (periphAddr) // [RULE_06] [RULE_22] [RULE_23]
            PA_COMPARE: next_st.buffer = {8'h00, st.compare}; // [RULE_08]
            PA_SHIFT:   next_st.buffer = {8'h00, st.shift};
            PA_MODULO:  next_st.buffer = {8'h00, st.modulo};
            PA_COUNT: begin
              next_st.buffer = st.countZero ? UNDEF_VAL : {8'h00, timerCount}; // [RULE_09]
            end
            PA_TABLE:   next_st.buffer = st.tablePtr; // [RULE_10]
            PA_STACK: begin
              next_st.buffer = stackTop; // [RULE_17]
              stackPop       = 1'b1;
            end
            PA_DIVIDE:  next_st.buffer = st.divide;
            PA_FREQ: begin
              next_st.buffer = st.freqZero ? UNDEF_VAL : freqCount; // [RULE_11]
            end
            default:    next_st.buffer = UNDEF_VAL; // [RULE_14]
          endcase
        end
        INSTR_STORE: begin
          case (periphAddr) // [RULE_07] [RULE_22] [RULE_23]
            PA_COMPARE: next_st.compare = st.buffer[BYTE_W-1:0]; // [RULE_08]
            PA_SHIFT:   next_st.shift   = st.buffer[BYTE_W-1:0];
            PA_MODULO:  next_st.modulo  = st.buffer[BYTE_W-1:0];
            PA_TABLE:   next_st.tablePtr = st.buffer; // [RULE_10]
            PA_STACK:   stackPush = 1'b1; // [RULE_16]
            PA_DIVIDE:  next_st.divide = st.buffer; // [RULE_12]
            default: begin
              // [RULE_14] load-only and unassigned stores change nothing;
              // a nibble write in the same cycle still lands
            end
          endcase
        end
        default: begin
          next_st.stackUse = 1'b0;
        end
      endcase
    end
    // control register writes; the level address takes no write
    if (ctrlWrite) begin
      case (ctrlAddr)
        CA_WIDTH:  next_st.narrow = ctrlWData[WIDTH_BIT]; // [RULE_04]
        CA_DIVLOW: next_st.divLow = ctrlWData[DIVLOW_BIT]; // [RULE_12]
        default:   next_st.narrow = next_st.narrow; // [RULE_20]
      endcase
    end
    // clock stop zeroes the counts and reloads the modulo value
    // stop beats a same-cycle update pulse, so the counts read zero after it
    if (clkStop) begin
      next_st.modulo    = MODULO_RST; // [RULE_13]
      next_st.countZero = 1'b1;       // [RULE_09]
      next_st.freqZero  = 1'b1;       // [RULE_11]
    end
    // watchdog reset acts like the pin reset on the documented registers
    if (wdtReset) begin
      next_st.tablePtr  = '0;         // [RULE_10]
      next_st.compare   = '0;
      next_st.modulo    = MODULO_RST; // [RULE_13]
      next_st.countZero = 1'b1;
      next_st.freqZero  = 1'b1;
      next_st.narrow    = 1'b0;
      next_st.divLow    = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // read paths; these are plain muxes of flops
  always_comb begin
    memHit   = bankHit;
    memRData = bankHit ? st.buffer[nibSel*NIB_W +: NIB_W] : '0; // [RULE_02]
    // unmapped control reads give zero rather than a floating value
    case (ctrlAddr)
      CA_LEVEL:  ctrlRData = {2'h0, stackLevel}; // [RULE_20]
      CA_WIDTH:  ctrlRData = {3'h0, st.narrow};
      CA_DIVLOW: ctrlRData = {3'h0, st.divLow};
      default:   ctrlRData = '0;
    endcase
  end

  assign progAddr       = st.tablePtr; // [RULE_03]
  assign addrStackUse   = st.stackUse;
  assign transferBuffer = st.buffer;
  assign compareValue   = st.compare;
  assign shiftValue     = st.shift;
  assign moduloValue    = st.modulo;
  assign divideValue    = {st.divide, st.divLow}; // [RULE_12]

  // properties watch registered results one edge after the take edge, the level read in its own cycle;
  // srst masks them because the state is forced then
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_table_word: assert property ( // [RULE_03]
    instrValid && instrKind == INSTR_TABLE && !st.narrow |=> st.buffer == $past(progData))
    else $error("table read word not taken");
  chk_table_byte: assert property ( // [RULE_04]
    instrValid && instrKind == INSTR_TABLE && st.narrow
    |=> st.buffer[15:8] == $past(st.buffer[15:8]) && st.buffer[7:0] == $past(progData[7:0]))
    else $error("byte table read disturbed upper nibbles");
  chk_table_level: assert property ( // [RULE_05]
    instrValid && instrKind == INSTR_TABLE |=> addrStackUse ##1 !addrStackUse || $past(instrValid))
    else $error("address stack level not held");
  chk_load_pointer: assert property ( // [RULE_10]
    instrValid && instrKind == INSTR_LOAD && periphAddr == PA_TABLE |=> st.buffer == $past(st.tablePtr))
    else $error("pointer load mismatch");
  chk_store_modulo: assert property ( // [RULE_08]
    instrValid && instrKind == INSTR_STORE && periphAddr == PA_MODULO && !clkStop && !wdtReset
    |=> moduloValue == $past(st.buffer[7:0]))
    else $error("modulo store lost");
  chk_stop_modulo: assert property ( // [RULE_13]
    clkStop |=> moduloValue == MODULO_RST)
    else $error("modulo not reloaded on clock stop");
  // the core issues the load two cycles after the stop; no update may come between
  chk_count_zero: assert property ( // [RULE_09]
    clkStop ##1 !timerUpdate ##1 instrValid && instrKind == INSTR_LOAD && periphAddr == PA_COUNT
    |=> st.buffer == UNDEF_VAL)
    else $error("timer count not zero after stop");
  chk_stack_push: assert property ( // [RULE_16]
    stackPush && !wdtReset |=> stackLevel == $past(stackLevel) + 2'h1 && $past(stackLevel) != stackLevel)
    else $error("stack pointer did not step up");
  chk_stack_pop: assert property ( // [RULE_17]
    stackPop && !wdtReset |=> stackLevel == $past(stackLevel) - 2'h1 && st.buffer == $past(stackTop))
    else $error("stack load mismatch");
  chk_unmapped_load: assert property ( // [RULE_14]
    instrValid && instrKind == INSTR_LOAD && periphAddr == 7'h7f |=> st.buffer == UNDEF_VAL)
    else $error("unassigned load not undefined value");
  // the level read has no write path at all; the stack owns the pointer
  chk_level_read: assert property ( // [RULE_20]
    ctrlAddr == CA_LEVEL |-> ctrlRData[3:2] == 2'h0 && ctrlRData[1:0] == stackLevel)
    else $error("level read wrong");
  // a compare store keeps only the low byte of the buffer
  chk_store_compare: assert property ( // [RULE_08]
    instrValid && instrKind == INSTR_STORE && periphAddr == PA_COMPARE && !wdtReset
    |=> compareValue == $past(st.buffer[BYTE_W-1:0]))
    else $error("compare store lost");
  // the table pointer takes all sixteen bits and feeds the program address
  chk_store_pointer: assert property ( // [RULE_10]
    instrValid && instrKind == INSTR_STORE && periphAddr == PA_TABLE && !wdtReset
    |=> progAddr == $past(st.buffer))
    else $error("pointer store lost");
  // the divider store fills the upper sixteen bits and leaves the low flag
  chk_store_divide: assert property ( // [RULE_12]
    instrValid && instrKind == INSTR_STORE && periphAddr == PA_DIVIDE && !wdtReset && !ctrlWrite
    |=> divideValue == {$past(st.buffer), $past(st.divLow)})
    else $error("divider store lost");
  // compare and modulo loads zero the upper half of the buffer
  chk_load_byte: assert property ( // [RULE_08]
    instrValid && instrKind == INSTR_LOAD && (periphAddr == PA_COMPARE || periphAddr == PA_MODULO)
    |=> st.buffer[BUF_W-1:BYTE_W] == '0)
    else $error("byte load left upper half");
  // a store to a load-only address must leave every target but the shift register alone
  chk_store_refused: assert property ( // [RULE_14]
    instrValid && instrKind == INSTR_STORE && (periphAddr == PA_COUNT || periphAddr == PA_FREQ)
    && !wdtReset && !clkStop && !ctrlWrite
    |=> compareValue == $past(compareValue) && moduloValue == $past(moduloValue)
    && progAddr == $past(progAddr) && divideValue == $past(divideValue) && stackLevel == $past(stackLevel))
    else $error("refused store changed a register");
  // the watchdog reset returns the stack level to zero
  chk_wdt_level: assert property ( // [RULE_20]
    wdtReset |=> stackLevel == 2'h0)
    else $error("level not cleared by watchdog reset");
endmodule

// >>> hw/dbfs_pkg.sv
// constants and types shared by the transfer buffer and its save stack
package dbfs_pkg;
  // data widths
  localparam int BUF_W   = 16;
  localparam int BYTE_W  = 8;
  localparam int NIB_W   = 4;
  localparam int ADDR_W  = 7;
  localparam int BANK_W  = 4;
  localparam int LEVEL_W = 2;
  localparam int DEPTH   = 4;
  // data memory placement of the buffer nibbles, msb nibble first
  localparam logic [BANK_W-1:0] DATA_BANK_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] NIB3_ADDR      = 7'h0c;
  localparam logic [ADDR_W-1:0] NIB2_ADDR      = 7'h0d;
  localparam logic [ADDR_W-1:0] NIB1_ADDR      = 7'h0e;
  localparam logic [ADDR_W-1:0] NIB0_ADDR      = 7'h0f;
  // peripheral addresses
  localparam logic [ADDR_W-1:0] PA_COMPARE = 7'h02;
  localparam logic [ADDR_W-1:0] PA_SHIFT   = 7'h04;
  localparam logic [ADDR_W-1:0] PA_MODULO  = 7'h1a;
  localparam logic [ADDR_W-1:0] PA_COUNT   = 7'h1b;
  localparam logic [ADDR_W-1:0] PA_TABLE   = 7'h40;
  localparam logic [ADDR_W-1:0] PA_STACK   = 7'h41;
  localparam logic [ADDR_W-1:0] PA_DIVIDE  = 7'h42;
  localparam logic [ADDR_W-1:0] PA_FREQ    = 7'h43;
  // control addresses and bit positions
  localparam logic [ADDR_W-1:0] CA_LEVEL  = 7'h04;
  localparam logic [ADDR_W-1:0] CA_WIDTH  = 7'h07;
  localparam logic [ADDR_W-1:0] CA_DIVLOW = 7'h10;
  localparam int WIDTH_BIT  = 0;
  localparam int DIVLOW_BIT = 0;
  // reset and fill values
  localparam logic [BYTE_W-1:0] MODULO_RST = 8'hff;
  localparam logic [BUF_W-1:0]  UNDEF_VAL  = 16'h0000;
  // instruction kinds presented by the core
  typedef enum logic [1:0] {
    INSTR_NONE,
    INSTR_TABLE,
    INSTR_LOAD,
    INSTR_STORE
  } dbfs_instr_type;
endpackage

// >>> hw/dbfs_stack.sv
// four-entry save stack for the transfer buffer with its level pointer
`timescale 1ns/1ps
module dbfs_stack
  import dbfs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               levelClear,
  input  wire logic               push,
  input  wire logic               pop,
  input  wire logic [BUF_W-1:0]   pushData,
  output logic      [BUF_W-1:0]   popData,
  output logic      [LEVEL_W-1:0] level
);
  // all state of the stack
  typedef struct packed {
    logic [DEPTH-1:0][BUF_W-1:0] entry; // saved words
    logic [LEVEL_W-1:0]          level; // wraps modulo four
  } dbfs_stack_type;

  dbfs_stack_type st;      // registered state
  dbfs_stack_type next_st; // next state

  // push writes at the pointer then steps up; pop reads there then steps down
  always_comb begin
    next_st = st;
    if (levelClear) begin
      next_st.level = '0;
    end else if (push) begin
      next_st.entry[st.level] = pushData; // [RULE_16] [RULE_19]
      next_st.level = st.level + 2'h1;    // [RULE_18]
    end else if (pop) begin
      next_st.level = st.level - 2'h1;    // [RULE_17]
    end
  end

  // entries are undefined after reset; cleared anyway for clean simulation
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign popData = st.entry[st.level]; // [RULE_17]
  assign level   = st.level;
endmodule
